// ### core/plc_pkg.sv
// Purpose: constants, types and register map of the programmable logic cell
// Assumes: 32-bit apb, byte addresses, one aligned word per register
// Notes: register offsets and field layout are local to this block

package plc_pkg;

   // ==========================================================================
   // bus and register map
   localparam int          ADDR_W      = 12;
   localparam int          DATA_W      = 32;
   localparam logic [11:0] OFS_LUT     = 12'h000;
   localparam logic [11:0] OFS_CONFIG  = 12'h004;
   localparam logic [11:0] OFS_STATUS  = 12'h008;

   localparam logic [15:0] LUT_RESET   = 16'h0000;
   localparam int          CFG_W       = 10;

   // ==========================================================================
   // status field positions
   localparam int          ST_LUT      = 0;
   localparam int          ST_REG      = 1;
   localparam int          ST_ROUTE_LO = 2;
   localparam int          ST_CHAIN    = 5;

   // ==========================================================================
   // modes and sources
   typedef enum logic [1:0] {
      FF_D, FF_T, FF_JK, FF_SR
   } plc_ff_mode_type;

   typedef enum logic [1:0] {
      SRC_LUT, SRC_DIRECT, SRC_CHAIN, SRC_SPARE
   } plc_src_type;

   // out_sel bit set: that output shows the register, else the table
   typedef struct packed {
      logic [1:0]      fb_sel;
      logic            fb_en;
      plc_src_type     reg_src;
      logic [2:0]      out_sel;
      plc_ff_mode_type ff_mode;
   } plc_cfg_type;

   localparam plc_cfg_type CFG_RESET = '{
      fb_sel: 2'h0, fb_en: 1'b0, reg_src: SRC_LUT,
      out_sel: 3'h0, ff_mode: FF_D};

   // cluster-wide controls shared by all cells of a cluster
   typedef struct packed {
      logic clk_ena;
      logic clear_n;
      logic sync_clear;
      logic sync_load;
      logic sync_load_data;
   } plc_cluster_type;

endpackage : plc_pkg

// ### core/plc_logic_cell.sv
// Purpose: one programmable logic cell with its apb configuration port
// Assumes: cell and cluster inputs are synchronous to pclk
// Notes: routed outputs carry the table result combinationally, or the register where out_sel is set

`timescale 1ns/1ps

module plc_logic_cell
   import plc_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [DATA_W-1:0]    pwdata,
   output      logic [DATA_W-1:0]    prdata,
   output      logic                 pready,
   output      logic                 pslverr,
   input  wire logic                 device_wide_clear_n,
   input  wire plc_cluster_type      cluster_ctl,
   input  wire logic [3:0]           data_in,
   input  wire logic                 cell_clk_ena,
   input  wire logic                 reg_data_in,
   input  wire logic                 reg_aux_in,
   input  wire logic                 chain_in,
   output      logic                 route_row_col,
   output      logic                 route_direct,
   output      logic                 route_local,
   output      logic                 chain_out
);

   // ==========================================================================
   // helpers
   function automatic logic pick(input logic sel_reg, input logic lut_v,
                                 input logic reg_v);
      pick = sel_reg ? reg_v : lut_v;
   endfunction : pick

   function automatic logic sel_hit(input logic [ADDR_W-1:0] a,
                                    input logic [11:0] ofs);
      sel_hit = (a == ofs);
   endfunction : sel_hit

   // ==========================================================================
   // configuration registers and apb slave
   logic [15:0]       lut_mask;
   logic [15:0]       next_lut_mask;
   plc_cfg_type       cfg;
   plc_cfg_type       next_cfg;
   logic [DATA_W-1:0] next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic [DATA_W-1:0] status_word;
   logic              mapped;
   logic              do_write;

   logic              reg_q;
   logic              lut_out;
   logic [2:0]        routed;

   always_comb begin
      status_word                 = '0;
      status_word[ST_LUT]         = lut_out;
      status_word[ST_REG]         = reg_q;
      status_word[ST_ROUTE_LO+:3] = routed;
      status_word[ST_CHAIN]       = chain_out;
   end

   always_comb begin
      mapped = sel_hit(paddr, OFS_LUT) | sel_hit(paddr, OFS_CONFIG)
             | sel_hit(paddr, OFS_STATUS);
      // write lands at the edge that closes the access phase
      do_write      = psel & penable & pready & pwrite & mapped;
      next_lut_mask = lut_mask;
      next_cfg      = cfg;
      if (do_write && sel_hit(paddr, OFS_LUT)) begin
         next_lut_mask = pwdata[15:0];
      end
      if (do_write && sel_hit(paddr, OFS_CONFIG)) begin
         next_cfg = plc_cfg_type'(pwdata[CFG_W-1:0]);
      end
      // answer prepared in setup so access takes exactly one cycle
      next_pready  = psel & ~penable & ~pready;
      next_pslverr = psel & ~penable & ~pready & ~mapped;
      next_prdata  = '0;
      if (psel && !penable && !pwrite) begin
         if (sel_hit(paddr, OFS_LUT)) begin
            next_prdata = {16'h0000, lut_mask};
         end else if (sel_hit(paddr, OFS_CONFIG)) begin
            next_prdata = {{(DATA_W-CFG_W){1'b0}}, cfg};
         end else if (sel_hit(paddr, OFS_STATUS)) begin
            next_prdata = status_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lut_mask <= LUT_RESET;
         cfg      <= CFG_RESET;
         prdata   <= '0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         lut_mask <= next_lut_mask;
         cfg      <= next_cfg;
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
      end
   end

   // ==========================================================================
   // look-up table with optional register feedback
   logic [3:0] lut_idx;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_idx
         // feedback replaces one table input by the cell's own register
         assign lut_idx[gi] = (cfg.fb_en && cfg.fb_sel == 2'(gi)) ?
                              reg_q : data_in[gi];
      end
   endgenerate

   assign lut_out = lut_mask[lut_idx];

   // ==========================================================================
   // storage register
   logic cell_rst_n;
   logic packed_use;
   logic clk_en;
   logic d_src;
   logic next_reg_q;

   // device clear folds into the asynchronous reset so it beats every control
   assign cell_rst_n = presetn & device_wide_clear_n
                     & cluster_ctl.clear_n;
   // any source other than SRC_LUT counts as packed use, even SRC_SPARE, which still loads the table
   assign packed_use = (cfg.reg_src != SRC_LUT);
   // cluster enable gates the clock of every register that shares it
   assign clk_en = cell_clk_ena & cluster_ctl.clk_ena;

   always_comb begin
      case (cfg.reg_src)
         SRC_LUT:    d_src = lut_out;
         SRC_DIRECT: d_src = reg_data_in;
         SRC_CHAIN:  d_src = chain_in;
         default:    d_src = lut_out;
      endcase
   end

   always_comb begin
      next_reg_q = reg_q;
      if (!clk_en) begin
         next_reg_q = reg_q;
      end else if (cluster_ctl.sync_clear) begin
         next_reg_q = 1'b0;
      end else if (cluster_ctl.sync_load && !packed_use) begin
         next_reg_q = cluster_ctl.sync_load_data;
      end else begin
         case (cfg.ff_mode)
            FF_D: next_reg_q = d_src;
            FF_T: next_reg_q = reg_q ^ d_src;
            FF_JK: begin
               case ({d_src, reg_aux_in})
                  2'b10:   next_reg_q = 1'b1;
                  2'b01:   next_reg_q = 1'b0;
                  2'b11:   next_reg_q = ~reg_q;
                  default: next_reg_q = reg_q;
               endcase
            end
            FF_SR: begin
               // both set and reset high holds: avoids an undefined state
               case ({d_src, reg_aux_in})
                  2'b10:   next_reg_q = 1'b1;
                  2'b01:   next_reg_q = 1'b0;
                  default: next_reg_q = reg_q;
               endcase
            end
            default: next_reg_q = d_src;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge cell_rst_n) begin
      if (!cell_rst_n) begin
         reg_q <= 1'b0;
      end else begin
         reg_q <= next_reg_q;
      end
   end

   // chain output is the register itself, so it is a flop
   assign chain_out = reg_q;

   // ==========================================================================
   // routed outputs
   generate
      for (gi = 0; gi < 3; gi++) begin : g_out
         // per-output source; table and register can show at once
         assign routed[gi] = pick(cfg.out_sel[gi], lut_out,
                                  reg_q);
      end
   endgenerate

   // two outputs to row/column and neighbour links, one to local routing
   assign route_row_col = routed[0];
   assign route_direct  = routed[1];
   assign route_local   = routed[2];

endmodule : plc_logic_cell

// ### verif/plc_asserts.sv
// Purpose: port checker for the programmable logic cell
// Assumes: bound to plc_logic_cell, one clock domain
// Notes: cell register state is seen through chain_out only
`timescale 1ns/1ps
module plc_asserts
   import plc_pkg::*;
(
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic            pready,
   input wire logic            device_wide_clear_n,
   input wire plc_cluster_type cluster_ctl,
   input wire logic [3:0]      data_in,
   input wire logic            cell_clk_ena,
   input wire logic            chain_out,
   input wire logic            route_row_col,
   input wire logic            route_direct,
   input wire logic            route_local
);
   // ===========
   // helpers
   logic clr_ok;
   logic ena_on;
   assign clr_ok = device_wide_clear_n && cluster_ctl.clear_n;
   assign ena_on = clr_ok && cell_clk_ena && cluster_ctl.clk_ena;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // clears must stay off across the whole gap, else q may drop legally
   sequence s_held(e);
      clr_ok && !e ##1 clr_ok;
   endsequence
   // no config commit, then table inputs and register unchanged
   sequence s_quiet;
      !(psel && penable && pready && pwrite) ##1
         ($stable(data_in) && $stable(chain_out));
   endsequence
   // ===========
   // assertions
   AST_DEV_CLEAR: assert property (!device_wide_clear_n |-> !chain_out)
      else $error("register not held clear by device clear");
   AST_CLU_CLEAR: assert property (!cluster_ctl.clear_n |-> !chain_out)
      else $error("register not held clear by cluster clear");
   AST_SYNC_CLEAR: assert property (ena_on && cluster_ctl.sync_clear |=> !chain_out)
      else $error("synchronous clear missed");
   AST_CELL_HOLD: assert property (s_held(cell_clk_ena) |-> $stable(chain_out))
      else $error("register moved with cell enable low");
   AST_CLUS_HOLD: assert property (s_held(cluster_ctl.clk_ena) |-> $stable(chain_out))
      else $error("register moved with cluster enable low");
   AST_COMB: assert property (s_quiet |->
      $stable({route_local, route_direct, route_row_col}))
      else $error("routed outputs moved without cause");
   AST_PREADY_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ANSWER: assert property (psel && !penable && !pready |=> pready)
      else $error("no answer after setup");
endmodule : plc_asserts

bind plc_logic_cell plc_asserts u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .device_wide_clear_n, .cluster_ctl, .data_in,
   .cell_clk_ena, .chain_out, .route_row_col, .route_direct, .route_local);

// ### verif/plc_neighbour.sv
// Purpose: neighbouring cells on the register chain
// Assumes: upstream and downstream cells share pclk
// Notes: plain flops, no logic of their own
`timescale 1ns/1ps
module plc_neighbour (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic up_data,
   input  wire logic chain_out,
   output      logic chain_in,
   output      logic down_q
);
   logic next_chain_in;
   logic next_down_q;
   always_comb begin
      next_chain_in = up_data;
      next_down_q   = chain_out;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_in <= 1'b0;
         down_q   <= 1'b0;
      end else begin
         chain_in <= next_chain_in;
         down_q   <= next_down_q;
      end
   end
endmodule : plc_neighbour

// ### verif/tb_top.sv
// Purpose: self-checking bench for the programmable logic cell
// Assumes: one enabled register edge per table row
// Notes: row exp is the status word after that edge
`timescale 1ns/1ps
module tb_top
   import plc_pkg::*;
;
   typedef struct packed {
      logic [11:0] cfg;
      logic [15:0] mask;
      logic [3:0]  din;
      logic [3:0]  ctl;
      logic [7:0]  exp;
   } plc_row_type;
   // ctl nibble: up_data, reg_aux_in, reg_data_in
   plc_row_type rows [12] = '{44'h000_8000_f_0_3f, 44'h000_8000_e_0_00,
      44'h029_8000_e_1_2a, 44'h029_8000_e_1_00, 44'h022_8000_e_1_22,
      44'h022_8000_e_3_00, 44'h023_8000_e_1_22, 44'h023_8000_e_3_22,
      44'h023_8000_e_2_00, 44'h010_8000_f_0_3f, 44'h040_0000_0_4_22,
      44'h080_5555_0_0_1d};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic device_wide_clear_n, cell_clk_ena, reg_data_in, reg_aux_in;
   logic chain_in, chain_out, route_row_col, route_direct, route_local;
   logic up_data, down_q, er;
   logic [3:0] data_in;
   plc_cluster_type cluster_ctl;
   int errors, n_compared, cycles;
   plc_logic_cell dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .device_wide_clear_n,
      .cluster_ctl, .data_in, .cell_clk_ena, .reg_data_in, .reg_aux_in,
      .chain_in, .route_row_col, .route_direct, .route_local, .chain_out);
   plc_neighbour u_nb (.pclk, .presetn, .up_data, .chain_out, .chain_in,
      .down_q);
   // ===========
   // tasks
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait2();
      repeat (2) @(posedge pclk);
   endtask : wait2
   // ===========
   // clock, timeout, sequence
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // the whole sequence needs well under a thousand cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         results();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {cell_clk_ena, reg_data_in, reg_aux_in, up_data, data_in} = '0;
      device_wide_clear_n = 1'b1;
      cluster_ctl = 5'h18;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         apb(1'b0, 12'(4 * k), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 12'h00c, 32'h0);
      chk(32'(er), 32'h1);
      $display("test reset and unmapped done");
      foreach (rows[i]) begin
         {up_data, reg_aux_in, reg_data_in} <= rows[i].ctl[2:0];
         data_in <= rows[i].din;
         apb(1'b1, OFS_CONFIG, 32'(rows[i].cfg));
         apb(1'b1, OFS_LUT, 32'(rows[i].mask));
         @(posedge pclk);
         cell_clk_ena <= 1'b1;
         @(posedge pclk);
         cell_clk_ena <= 1'b0;
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(rd, 32'(rows[i].exp));
         chk(32'({route_local, route_direct, route_row_col}),
             32'(rows[i].exp[4:2]));
         chk(32'(down_q), 32'(rows[i].exp[5]));
         $display("test row %0d done", i);
      end
      apb(1'b1, OFS_CONFIG, 32'h0);
      apb(1'b1, OFS_LUT, 32'hffff);
      cell_clk_ena <= 1'b1;
      cluster_ctl.sync_load_data <= 1'b1;
      cluster_ctl.sync_load <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         if (k == 0) device_wide_clear_n <= 1'b0;
         else cluster_ctl.clear_n <= 1'b0;
         wait2();
         chk(32'(chain_out), 32'h0);
         device_wide_clear_n <= 1'b1;
         cluster_ctl.clear_n <= 1'b1;
         wait2();
         chk(32'(chain_out), 32'h1);
      end
      cluster_ctl.sync_clear <= 1'b1;
      wait2();
      chk(32'(chain_out), 32'h0);
      cluster_ctl.sync_clear <= 1'b0;
      apb(1'b1, OFS_LUT, 32'h0);
      chk(32'(chain_out), 32'h1);
      apb(1'b1, OFS_CONFIG, 32'h20);
      wait2();
      chk(32'(chain_out), 32'h0);
      cluster_ctl.clk_ena <= 1'b0;
      reg_data_in <= 1'b1;
      wait2();
      chk(32'(chain_out), 32'h0);
      // configuration read-back, then a mid-run reset must clear it
      apb(1'b0, OFS_CONFIG, 32'h0);
      chk(rd, 32'h20);
      presetn <= 1'b0;
      wait2();
      presetn <= 1'b1;
      apb(1'b0, OFS_CONFIG, 32'h0);
      chk(rd, 32'h0);
      $display("test clears, loads and enables done");
      results();
   end
endmodule : tb_top
